// >>> rtl/wtp_pkg.sv
package wtp_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SET = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CAP = 8'h0c;
  localparam logic [7:0] OFF_CHTYPE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // power levels
  // ----------------------------------------------------------------
  localparam int unsigned LVL_W = 3;
  localparam int unsigned NUM_LEVELS = 8;
  localparam logic [3:0] STEP_DB = 4'h2;
  localparam logic [2:0] LVL_DEFAULT = 3'h0;
  localparam int unsigned ENT_W = 2 * LVL_W;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_CHAN_POS = 0;
  localparam int unsigned CTRL_DETACH_POS = 8;
  localparam int unsigned SET_LVL_POS = 0;
  localparam int unsigned SET_NOTIF_POS = 4;
  localparam int unsigned SET_CHAN_POS = 8;
  localparam int unsigned STAT_DATA_POS = 0;
  localparam int unsigned STAT_NOTIF_POS = 4;
  localparam int unsigned STAT_CHAN_POS = 8;
  localparam int unsigned CAP_HOP_STEP_POS = 0;
  localparam int unsigned CAP_HOP_CNT_POS = 4;
  localparam int unsigned CAP_FIX_STEP_POS = 8;
  localparam int unsigned CAP_FIX_CNT_POS = 12;
  localparam int unsigned ENT_DATA_POS = 0;
  localparam int unsigned ENT_NOTIF_POS = 3;

  // ----------------------------------------------------------------
  // interrupt bits and bus encodings
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_SET_BIT = 0;
  localparam int unsigned IRQ_CLAMP_BIT = 1;
  localparam int unsigned IRQ_DETACH_BIT = 2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WR,
    BUS_RD
  } wtp_bus_t;

endpackage : wtp_pkg

// >>> rtl/wtp_lvl_mem.sv
`timescale 1ns/1ps
module wtp_lvl_mem #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW = 2,
  parameter int unsigned W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] wmask,
  input wire logic [AW-1:0] ra_addr,
  output logic [W-1:0] ra_data,
  input wire logic [AW-1:0] rb_addr,
  output logic [W-1:0] rb_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [W-1:0] ra;
    logic [W-1:0] rb;
  } wtp_mem_st_t;

  wtp_mem_st_t s_q;
  wtp_mem_st_t s_d;

  // reads are write-first so a setting taken on an edge is seen by a
  // read on that same edge; an all-zero entry is the highest power
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < DEPTH; i++) begin
      if (clr) begin
        s_d.ent[i] = '0;
      end else if (we && waddr == AW'(i)) begin
        s_d.ent[i] = (s_q.ent[i] & ~wmask) | (wdata & wmask);
      end
    end
    s_d.ra = (int'(ra_addr) < DEPTH) ? s_d.ent[ra_addr] : '0;
    s_d.rb = (int'(rb_addr) < DEPTH) ? s_d.ent[rb_addr] : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ra_data = s_q.ra;
  assign rb_data = s_q.rb;

endmodule : wtp_lvl_mem

// >>> rtl/wtp_tx_power.sv
`timescale 1ns/1ps
module wtp_tx_power
  import wtp_pkg::*;
#(
  parameter int unsigned NUM_CH = 4,
  parameter int unsigned HOP_LEVELS = wtp_pkg::NUM_LEVELS,
  parameter int unsigned FIX_LEVELS = wtp_pkg::NUM_LEVELS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic detach_evt,
  input wire logic tx_req,
  input wire logic tx_notif,
  input wire logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] tx_chan,
  output logic tx_go,
  output logic [wtp_pkg::LVL_W-1:0] tx_level,
  output logic [3:0] tx_atten_db,
  output logic irq
);
  import wtp_pkg::*;

  localparam int unsigned CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam logic [LVL_W-1:0] HOP_MAX = LVL_W'(HOP_LEVELS - 1);
  localparam logic [LVL_W-1:0] FIX_MAX = LVL_W'(FIX_LEVELS - 1);
  localparam logic [ENT_W-1:0] MASK_DATA = ENT_W'(7) << ENT_DATA_POS;
  localparam logic [ENT_W-1:0] MASK_NOTIF = ENT_W'(7) << ENT_NOTIF_POS;
  localparam logic [31:0] CAP_VALUE =
      (32'(STEP_DB) << CAP_HOP_STEP_POS) |
      (32'(HOP_LEVELS) << CAP_HOP_CNT_POS) |
      (32'(STEP_DB) << CAP_FIX_STEP_POS) |
      (32'(FIX_LEVELS) << CAP_FIX_CNT_POS);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    wtp_bus_t bus;
    logic [7:0] addr;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic [CHW-1:0] chan_sel;
    logic [NUM_CH-1:0] chtype;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic req;
    logic req_notif;
    logic go;
    logic [LVL_W-1:0] level;
    logic [3:0] atten;
  } wtp_top_st_t;

  wtp_top_st_t s_q;
  wtp_top_st_t s_d;

  logic wr_act;
  logic wr_ctrl;
  logic wr_set;
  logic detach;
  logic [LVL_W-1:0] req_lvl;
  logic [LVL_W-1:0] set_max;
  logic [LVL_W-1:0] set_lvl;
  logic [CHW-1:0] set_chan;
  logic set_notif;
  logic mem_we;
  logic [ENT_W-1:0] mem_wdata;
  logic [ENT_W-1:0] mem_wmask;
  logic [IRQ_W-1:0] ev;
  logic [31:0] rd_val;
  logic [ENT_W-1:0] ra_data;
  logic [ENT_W-1:0] rb_data;
  logic [LVL_W-1:0] pick;

  // ----------------------------------------------------------------
  // per-channel level store
  // ----------------------------------------------------------------
  wtp_lvl_mem #(
    .DEPTH(NUM_CH),
    .AW(CHW),
    .W(ENT_W)
  ) wtp_lvl_mem_i (
    .clk(hclk),
    .rst_n(hresetn),
    .clr(detach),
    .we(mem_we),
    .waddr(set_chan),
    .wdata(mem_wdata),
    .wmask(mem_wmask),
    .ra_addr(tx_chan),
    .ra_data(ra_data),
    .rb_addr(s_q.chan_sel),
    .rb_data(rb_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev = '0;
    wr_act = (s_q.bus == BUS_WR);
    wr_ctrl = wr_act && (s_q.addr == OFF_CTRL);
    wr_set = wr_act && (s_q.addr == OFF_SET);
    req_lvl = hwdata[SET_LVL_POS +: LVL_W];
    set_notif = hwdata[SET_NOTIF_POS];
    set_chan = hwdata[SET_CHAN_POS +: CHW];
    set_max = HOP_MAX;
    if (int'(set_chan) < NUM_CH && s_q.chtype[set_chan]) begin
      set_max = FIX_MAX;
    end
    // out-of-range request parks at the weakest supported setting
    set_lvl = (req_lvl > set_max) ? set_max : req_lvl;
    detach = detach_evt || (wr_ctrl && hwdata[CTRL_DETACH_POS]);
    // no busy window: a setting is taken in any cycle it arrives, except one where a detach clears the store
    mem_we = wr_set && (int'(set_chan) < NUM_CH);
    mem_wmask = set_notif ? MASK_NOTIF : MASK_DATA;
    mem_wdata = {set_lvl, set_lvl};
    if (mem_we) begin
      ev[IRQ_SET_BIT] = 1'b1;
      ev[IRQ_CLAMP_BIT] = (req_lvl > set_max);
    end
    ev[IRQ_DETACH_BIT] = detach;

    // ------------------------------------------------------------
    // bus: address phase capture, read data registered here
    // ------------------------------------------------------------
    rd_val = '0;
    case (haddr[7:0] & 8'hfc)
      OFF_CTRL: begin
        rd_val[CTRL_CHAN_POS +: CHW] = s_q.chan_sel;
      end
      OFF_STATUS: begin
        rd_val[STAT_DATA_POS +: LVL_W] =
            rb_data[ENT_DATA_POS +: LVL_W];
        rd_val[STAT_NOTIF_POS +: LVL_W] = rb_data[ENT_NOTIF_POS +: LVL_W];
        rd_val[STAT_CHAN_POS +: CHW] = s_q.chan_sel;
      end
      OFF_CAP: begin
        rd_val = CAP_VALUE;
      end
      OFF_CHTYPE: begin
        rd_val[NUM_CH-1:0] = s_q.chtype;
      end
      OFF_IRQ_STAT: begin
        rd_val[IRQ_W-1:0] = s_q.irq_stat;
      end
      OFF_IRQ_MASK: begin
        rd_val[IRQ_W-1:0] = s_q.irq_mask;
      end
      default: begin
        rd_val = '0;
      end
    endcase
    s_d.bus = BUS_IDLE;
    s_d.rdy = 1'b1;
    s_d.resp = 1'b0;
    if (hready && hsel && htrans[1]) begin
      s_d.addr = haddr[7:0] & 8'hfc;
      if (hwrite && hsize == HSIZE_WORD) begin
        s_d.bus = BUS_WR;
      end else if (!hwrite) begin
        s_d.bus = BUS_RD;
        s_d.rdata = rd_val;
      end
    end

    // ------------------------------------------------------------
    // register writes (data phase)
    // ------------------------------------------------------------
    if (wr_ctrl) begin
      s_d.chan_sel = hwdata[CTRL_CHAN_POS +: CHW];
    end
    if (wr_act && s_q.addr == OFF_CHTYPE) begin
      s_d.chtype = hwdata[NUM_CH-1:0];
    end
    if (wr_act && s_q.addr == OFF_IRQ_MASK) begin
      s_d.irq_mask = hwdata[IRQ_W-1:0];
    end
    // set wins over a same-cycle write-one clear
    if (wr_act && s_q.addr == OFF_IRQ_STAT) begin
      s_d.irq_stat = s_q.irq_stat & ~hwdata[IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // ------------------------------------------------------------
    // transmit path: level read on the request edge, out next edge
    // ------------------------------------------------------------
    s_d.req = tx_req;
    s_d.req_notif = tx_notif;
    pick = s_q.req_notif ? ra_data[ENT_NOTIF_POS +: LVL_W]
                         : ra_data[ENT_DATA_POS +: LVL_W];
    s_d.go = s_q.req;
    if (s_q.req) begin
      s_d.level = pick;
      s_d.atten = 4'(pick) * STEP_DB;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.rdy;
  assign hresp = s_q.resp;
  assign hrdata = s_q.rdata;
  assign tx_go = s_q.go;
  assign tx_level = s_q.level;
  assign tx_atten_db = s_q.atten;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic rd_cap;
  logic rd_stat;
  assign rd_cap = hready && hsel && htrans[1] && !hwrite &&
                  (haddr[7:0] & 8'hfc) == OFF_CAP;
  assign rd_stat = hready && hsel && htrans[1] && !hwrite &&
                   (haddr[7:0] & 8'hfc) == OFF_STATUS;

  property p_detach_default;
    (detach && tx_req) |-> ##2 (tx_go && tx_level == LVL_DEFAULT);
  endproperty
  a_detach_default: assert property (p_detach_default)
    else $error("detach did not restore highest power");

  property p_go_cause;
    tx_go |-> $past(tx_req, 2);
  endproperty
  a_go_cause: assert property (p_go_cause)
    else $error("transmit strobe without a request");

  property p_next_packet;
    (mem_we && !detach && tx_req && tx_chan == set_chan &&
     tx_notif == set_notif && req_lvl <= set_max)
      |-> ##2 (tx_go && tx_level == $past(req_lvl, 2));
  endproperty
  a_next_packet: assert property (p_next_packet)
    else $error("new setting not used on the next packet");

  property p_clamp;
    (mem_we && !detach && tx_req && tx_chan == set_chan &&
     tx_notif == set_notif && req_lvl > set_max)
      |-> ##2 (tx_level == $past(set_max, 2));
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("unsupported setting not held at weakest level");

  property p_step;
    tx_go |-> (tx_atten_db == {tx_level, 1'b0});
  endproperty
  a_step: assert property (p_step)
    else $error("attenuation is not two dB per step");

  property p_separate;
    (mem_we && set_notif && !detach && !wr_ctrl && !$past(wr_ctrl))
      |=> (rb_data[ENT_DATA_POS +: LVL_W] ==
           $past(rb_data[ENT_DATA_POS +: LVL_W]));
  endproperty
  a_separate: assert property (p_separate)
    else $error("notification write changed data level");

  // a channel-select write one edge earlier legally moves the status view
  property p_isolate;
    (mem_we && set_chan != s_q.chan_sel && !detach && !wr_ctrl &&
     !$past(wr_ctrl))
      |=> (rb_data == $past(rb_data));
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("write leaked into another channel");

  property p_cap;
    rd_cap |=> (hrdata == CAP_VALUE && hreadyout);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability word wrong");

  property p_status;
    rd_stat |=> (hrdata[STAT_NOTIF_POS +: LVL_W] ==
                 $past(rb_data[ENT_NOTIF_POS +: LVL_W]));
  endproperty
  a_status: assert property (p_status)
    else $error("status read does not show current level");

  property p_any_time;
    (mem_we && !detach) |=> (s_q.irq_stat[IRQ_SET_BIT] && hreadyout);
  endproperty
  a_any_time: assert property (p_any_time)
    else $error("setting not accepted");

  // level only moves with a strobe, so a packet never sees a torn update
  property p_level_hold;
    !tx_go |-> $stable(tx_level);
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("transmit level moved without a packet");

  property p_detach_clear;
    detach |=> (rb_data == '0);
  endproperty
  a_detach_clear: assert property (p_detach_clear)
    else $error("detach left a stored level behind");

  c_detach: cover property (detach ##1 tx_req ##2 tx_go);
  c_clamp: cover property (mem_we && req_lvl > set_max);
  c_notif: cover property (tx_req && tx_notif ##2 tx_level != 3'h0);
  c_irq: cover property (!irq ##1 irq);
  c_race: cover property (mem_we && tx_req && tx_chan == set_chan);

endmodule : wtp_tx_power

// >>> bench/wtp_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// host retry policy seen from the air side
// ------------------------------------------------
module wtp_host_model
  import wtp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_go,
  input wire logic [wtp_pkg::LVL_W-1:0] tx_level,
  input wire logic pipe_iso,
  input wire logic pipe_lp_int,
  output logic stalled,
  output logic [3:0] retry_q
);
  localparam logic [3:0] MIN_TRIES = 4'h7;
  // packets sent this weak are taken as lost on the air
  localparam logic [2:0] WEAK = 3'h6;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retry_q <= 4'h0;
      stalled <= 1'b0;
    end else if (tx_go && !stalled) begin
      if (tx_level < WEAK) begin
        retry_q <= 4'h0;
      end else if (!pipe_iso && !pipe_lp_int) begin
        // a silent endpoint is judged elsewhere, not by count
        if (retry_q >= MIN_TRIES - 4'h1) begin
          stalled <= 1'b1;
        end else begin
          retry_q <= retry_q + 4'h1;
        end
      end
    end
  end
endmodule : wtp_host_model

// >>> bench/wtp_tx_power_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module wtp_tx_power_bench;
  import wtp_pkg::*;
  localparam int unsigned FIXL = 6;
  typedef struct packed {
    logic [2:0] lvl;
    logic nt;
    logic [1:0] ch;
    logic [2:0] ex;
  } wtp_row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, tx_chan;
  logic [2:0] hsize, tx_level;
  logic detach_evt, tx_req, tx_notif, tx_go, irq, stalled;
  logic pipe_iso, pipe_lp_int;
  logic [3:0] tx_atten_db, retry_q;
  logic [2:0] cur [4][2];
  wtp_row_t rows [16];
  int err_count = 0;
  int num_checks = 0;
  assign hready = hreadyout;

  wtp_tx_power #(.FIX_LEVELS(FIXL)) wtp_tx_power_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .detach_evt(detach_evt), .tx_req(tx_req),
    .tx_notif(tx_notif), .tx_chan(tx_chan), .tx_go(tx_go),
    .tx_level(tx_level), .tx_atten_db(tx_atten_db), .irq(irq));
  wtp_host_model wtp_host_model_i (
    .hclk(hclk), .hresetn(hresetn), .tx_go(tx_go), .tx_level(tx_level),
    .pipe_iso(pipe_iso), .pipe_lp_int(pipe_lp_int), .stalled(stalled),
    .retry_q(retry_q));

  // ------------------------------------------------
  // bus and packet tasks
  // ------------------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("hrdata", e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : rdc

  // status follows the channel select one edge late, so let it settle
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic txc(input logic nt, input logic [1:0] c,
                     input logic [2:0] e);
    tx_req <= 1'b1;
    tx_notif <= nt;
    tx_chan <= c;
    @(posedge hclk);
    tx_req <= 1'b0;
    @(posedge hclk);
    #1;
    `CHK("tx_go", 1'b1, tx_go)
    `CHK("tx_level", e, tx_level)
    `CHK("tx_atten_db", {e, 1'b0}, tx_atten_db)
    @(posedge hclk);
  endtask : txc

  // packet request sampled on the very edge that writes the setting
  task automatic race(input logic [31:0] d, input logic nt,
                      input logic [1:0] c, input logic [2:0] e);
    fork
      bus(1'b1, OFF_SET, d);
      begin
        @(posedge hclk);
        txc(nt, c, e);
      end
    join
  endtask : race

  // the host model updates on the edge that ends txc, so look just after
  task automatic hostc(input logic s, input logic [3:0] r);
    #1;
    `CHK("stalled", s, stalled)
    `CHK("retry_q", r, retry_q)
    @(posedge hclk);
  endtask : hostc

  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    rows = '{'{3'h7, 1'b0, 2'h0, 3'h7}, '{3'h3, 1'b1, 2'h0, 3'h3},
      '{3'h1, 1'b0, 2'h1, 3'h1}, '{3'h6, 1'b1, 2'h1, 3'h6},
      '{3'h2, 1'b0, 2'h2, 3'h2}, '{3'h5, 1'b1, 2'h2, 3'h5},
      '{3'h7, 1'b0, 2'h3, 3'h5}, '{3'h6, 1'b1, 2'h3, 3'h5},
      '{3'h4, 1'b0, 2'h3, 3'h4}, '{3'h5, 1'b1, 2'h3, 3'h5},
      '{3'h0, 1'b0, 2'h0, 3'h0}, '{3'h1, 1'b1, 2'h2, 3'h1},
      '{3'h3, 1'b0, 2'h2, 3'h3}, '{3'h2, 1'b1, 2'h1, 3'h2},
      '{3'h4, 1'b1, 2'h0, 3'h4}, '{3'h0, 1'b1, 2'h3, 3'h0}};
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = HSIZE_WORD;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    detach_evt = 1'b0;
    tx_req = 1'b0;
    tx_notif = 1'b0;
    tx_chan = 2'h0;
    pipe_iso = 1'b0;
    pipe_lp_int = 1'b0;
    foreach (cur[i, j]) cur[i][j] = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("irq", 1'b0, irq)
    rdc(OFF_CAP, {16'h0, 4'(FIXL), STEP_DB, 4'(NUM_LEVELS), STEP_DB});
    rdc(OFF_STATUS, 32'h0);
    rdc(8'h1c, 32'h0);
    bus(1'b1, OFF_CHTYPE, 32'h8);
    rdc(OFF_CHTYPE, 32'h8);
    for (int r = 0; r < 16; r++) begin
      bus(1'b1, OFF_SET, {22'h0, rows[r].ch, 3'h0, rows[r].nt, 1'b0,
                         rows[r].lvl});
      cur[rows[r].ch][rows[r].nt] = rows[r].ex;
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < 2; k++) begin
          txc(k[0], c[1:0], cur[c][k]);
        end
      end
    end
    bus(1'b1, OFF_CTRL, 32'h3);
    idle(2);
    rdc(OFF_STATUS, 32'h00000304);
    rdc(OFF_IRQ_STAT, 32'h3);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, OFF_IRQ_MASK, 32'h7);
    idle(2);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, OFF_IRQ_STAT, 32'h3);
    idle(2);
    `CHK("irq", 1'b0, irq)
    // packets launched in the very data phase of the setting
    race(32'h00000106, 1'b0, 2'h1, 3'h6);
    race(32'h00000307, 1'b0, 2'h3, 3'h5);
    // detach lands on the same edge as a packet request
    fork
      begin
        detach_evt <= 1'b1;
        @(posedge hclk);
        detach_evt <= 1'b0;
      end
      txc(1'b0, 2'h3, 3'h0);
    join
    idle(2);
    `CHK("irq", 1'b1, irq)
    rdc(OFF_IRQ_STAT, 32'h7);
    for (int c = 0; c < 4; c++) begin
      txc(1'b1, c[1:0], 3'h0);
      txc(1'b0, c[1:0], 3'h0);
    end
    bus(1'b1, OFF_SET, 32'h00000003);
    bus(1'b1, OFF_CTRL, 32'h00000100);
    txc(1'b0, 2'h0, 3'h0);
    // host retry policy fed by weak packets on channel 0
    bus(1'b1, OFF_SET, 32'h00000007);
    pipe_iso <= 1'b1;
    repeat (8) txc(1'b0, 2'h0, 3'h7);
    hostc(1'b0, 4'h0);
    pipe_iso <= 1'b0;
    pipe_lp_int <= 1'b1;
    repeat (8) txc(1'b0, 2'h0, 3'h7);
    hostc(1'b0, 4'h0);
    pipe_lp_int <= 1'b0;
    repeat (3) txc(1'b0, 2'h0, 3'h7);
    hostc(1'b0, 4'h3);
    txc(1'b1, 2'h0, 3'h0);
    hostc(1'b0, 4'h0);
    repeat (6) txc(1'b0, 2'h0, 3'h7);
    hostc(1'b0, 4'h6);
    txc(1'b0, 2'h0, 3'h7);
    hostc(1'b1, 4'h6);
    print_verdict();
  end
endmodule : wtp_tx_power_bench
